// >>> access_port_checker_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module access_port_checker (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Host side
  input wire host_wr_stb,
  input wire [35:0] host_wr_data,
  input wire [35:0] host_rd_data_ff,
  input wire host_rd_valid_ff,
  input wire host_busy_ff,
  input wire register_access_error_ff,
  input wire err_irq_ff,
  // Control bus
  input wire ext_demand_ff,
  input wire ext_write_ff,
  input wire [4:0] ext_rs_ff,
  input wire [2:0] ext_ds_ff,
  input wire [15:0] ext_dout_ff,
  input wire ext_par_out_ff,
  input wire ext_dout_oe_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_irq_err;
    err_irq_ff |-> register_access_error_ff;
  endproperty
  a_irq_err: assert property (p_irq_err) else $error("irq without error");
  property p_wr_fields;
    $rose(ext_demand_ff) && ext_write_ff |->
      ext_dout_ff == $past(host_wr_data[35:20]) && ext_rs_ff == $past(host_wr_data[4:0]);
  endproperty
  a_wr_fields: assert property (p_wr_fields) else $error("write fields wrong");
  property p_wr_drive;
    $rose(ext_demand_ff) && ext_write_ff |-> ext_ds_ff == $past(host_wr_data[17:15]);
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("drive number wrong");
  property p_wr_par;
    $rose(ext_demand_ff) && ext_write_ff |->
      ext_par_out_ff == (~^ext_dout_ff ^ $past(host_wr_data[18]));
  endproperty
  a_wr_par: assert property (p_wr_par) else $error("write parity wrong");
  property p_wr_blocked;
    err_irq_ff && host_wr_stb && !host_busy_ff |=> !host_busy_ff && !ext_demand_ff;
  endproperty
  a_wr_blocked: assert property (p_wr_blocked) else $error("blocked write ran");
  property p_par_err;
    host_rd_valid_ff && host_rd_data_ff[8] |-> register_access_error_ff;
  endproperty
  a_par_err: assert property (p_par_err) else $error("parity error not flagged");
  property p_no_resp;
    host_rd_valid_ff && !host_rd_data_ff[10] |-> host_rd_data_ff[35:19] == 17'h00000;
  endproperty
  a_no_resp: assert property (p_no_resp) else $error("data without response");
  property p_busy_bound;
    $rose(host_busy_ff) |-> ##[1:120] !host_busy_ff;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("bus cycle hung");
  property p_oe_match;
    ext_dout_oe_ff == (ext_demand_ff && ext_write_ff);
  endproperty
  a_oe_match: assert property (p_oe_match) else $error("data enable wrong");
  cover property (ext_demand_ff && ext_write_ff);
  cover property (host_rd_valid_ff && host_rd_data_ff[8]);
  cover property ($rose(register_access_error_ff) && !err_irq_ff);
endmodule
`default_nettype wire

// >>> drive_access_map.vh
`ifndef DRIVE_ACCESS_MAP_VH
`define DRIVE_ACCESS_MAP_VH

// Host instruction word fields (bit n of the word is index n)
`define RS_LSB 0
`define RS_MSB 5
`define RS_INT_BIT 5
`define LR_BIT 6
`define CONTROL_PARITY_ERROR_BIT 8
`define DIS_BIT 9
`define TRA_BIT 10
`define B14_BIT 14
`define DS_LSB 15
`define DS_MSB 17
`define FEP_BIT 18
`define CPA_BIT 19
`define ERD_LSB 20
`define ERD_MSB 35

// Register select codes
`define RS_SEC_CMD 6'h20
`define REG_CS1 5'h00
`define REG_IB 5'h02
`define REG_OB 5'h07

// Interface unit register fields
`define CS1_CMD_MSB 5
`define CS1_READY_BIT 11
`define CS1_RESET 6'h00
`define OB_RESET 16'h0000

// Drive number answered by the attached interface unit (shipped as 7)
`define LOCAL_UNIT 3'h7

// Reset values
`define PREP_RS_RESET 6'h00
`define PREP_DS_RESET 3'h0
`define WORD_RESET 36'h000000000
`define DATA_RESET 16'h0000
`define CNT_RESET 7'h00
`define CNT_ONE 7'h01

// No-response timeout
`define CLK_PERIOD_NS 20
`define NXD_TIME_NS 1500
`define NXD_CYCLES (`NXD_TIME_NS / `CLK_PERIOD_NS)

`endif

// >>> drive_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module drive_bus_model #(parameter int NUM_DRIVES = 4) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control bus
  input wire logic demand,
  input wire logic write,
  input wire logic [4:0] rs,
  input wire logic [2:0] ds,
  input wire logic [15:0] dout,
  input wire logic par_out,
  output logic [15:0] din,
  output logic par_in,
  output logic transfer,
  // Bench control
  input wire logic [3:0] delay,
  input wire logic bad_par
);
  logic [15:0] regs [0:255];
  logic [3:0] wait_cnt;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      din <= 16'h0000;
      par_in <= 1'b0;
      transfer <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (!demand || ds >= NUM_DRIVES) begin
      // Released lines toggle so stale data never looks valid
      din <= ~din;
      par_in <= ~par_in;
      transfer <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt == delay) begin
      transfer <= 1'b1;
      // words with even parity are refused
      if (write && !transfer && (^dout ^ par_out)) begin
        regs[{ds, rs}] <= dout;
      end
      // odd parity unless told to corrupt it
      if (!write) begin
        din <= regs[{ds, rs}];
        par_in <= ~^regs[{ds, rs}] ^ bad_par;
      end
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> drive_register_access_port.v
`include "drive_access_map.vh"
`timescale 1ns/1ns
`default_nettype none

module drive_register_access_port (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Host instruction port
  input wire host_wr_stb,
  input wire [35:0] host_wr_data,
  input wire host_rd_stb,
  input wire host_err_clear,
  output reg [35:0] host_rd_data_ff,
  output reg host_rd_valid_ff,
  output reg host_busy_ff,
  output reg register_access_error_ff,
  output reg err_irq_ff,
  // External drive control bus
  output reg ext_demand_ff,
  output reg ext_write_ff,
  output reg [4:0] ext_rs_ff,
  output reg [2:0] ext_ds_ff,
  output reg [15:0] ext_dout_ff,
  output reg ext_dout_oe_ff,
  output reg ext_par_out_ff,
  input wire [15:0] ext_din,
  input wire ext_par_in,
  input wire ext_transfer,
  // User side of the attached interface unit
  input wire [15:0] user_data_in,
  output wire [15:0] user_data_out_ff,
  output wire [5:0] command_ff
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_LOCAL = 2'b01;
  localparam [1:0] ST_EXT_WAIT = 2'b10;
  localparam [1:0] ST_EXT_REL = 2'b11;
  localparam integer NXD_FULL = `NXD_CYCLES;
  localparam [6:0] NXD_CNT = NXD_FULL[6:0];

  // Preparation register
  reg [5:0] prep_rs_ff;
  reg [2:0] prep_ds_ff;
  reg prep_lr_ff, prep_dis_ff, prep_b14_ff, prep_fep_ff;

  reg [1:0] state_ff;
  reg [6:0] cnt_ff;
  reg [4:0] tgt_rs_ff;
  reg [15:0] tgt_data_ff;
  reg op_wr_ff, unit_sel_ff, tgt_par_ff;

  // Synchronisers for the external bus inputs
  reg [17:0] ext_meta_ff;
  reg [17:0] ext_sync_ff;
  wire [15:0] ext_din_s;
  wire ext_par_s, tra_s;

  wire [15:0] unit_rdata;
  wire unit_ack, unit_rpar, unit_par_err;

  wire [5:0] w_rs;
  wire [2:0] w_ds;
  wire [15:0] w_data, cap_data;
  wire blocked, wr_take, rd_take;
  wire w_lr, w_fep, w_ext, w_sec;
  wire fin_local, fin_ext, fin_nxd, fin;
  wire cap_par, cap_perr, nxt_rae, nxt_dis;

  // Odd parity bit for a control bus word
  function odd_par;
    input [15:0] d;
    begin
      odd_par = ~(^d);
    end
  endfunction

  // Read result built around the preparation register
  function [35:0] pack_result;
    input control_parity_error;
    input drive_responded;
    input received_parity_bit;
    input [15:0] external_reg_data;
    begin
      pack_result = `WORD_RESET;
      pack_result[`RS_MSB:`RS_LSB] = prep_rs_ff;
      pack_result[`LR_BIT] = prep_lr_ff;
      pack_result[`DS_MSB:`DS_LSB] = prep_ds_ff;
      pack_result[`CONTROL_PARITY_ERROR_BIT] = control_parity_error;
      pack_result[`DIS_BIT] = prep_dis_ff;
      pack_result[`TRA_BIT] = drive_responded;
      pack_result[`CPA_BIT] = received_parity_bit;
      pack_result[`ERD_MSB:`ERD_LSB] = external_reg_data;
    end
  endfunction

  assign ext_din_s = ext_sync_ff[15:0];
  assign ext_par_s = ext_sync_ff[16];
  assign tra_s = ext_sync_ff[17];

  assign blocked = register_access_error_ff & ~prep_dis_ff;
  assign wr_take = (state_ff == ST_IDLE) & host_wr_stb & ~blocked;
  assign rd_take = (state_ff == ST_IDLE) & host_rd_stb & ~host_wr_stb;

  assign w_rs = host_wr_data[`RS_MSB:`RS_LSB];
  assign w_lr = host_wr_data[`LR_BIT];
  assign w_ds = host_wr_data[`DS_MSB:`DS_LSB];
  assign w_data = host_wr_data[`ERD_MSB:`ERD_LSB];
  assign w_fep = host_wr_data[`FEP_BIT];
  assign w_ext = w_lr & ~w_rs[`RS_INT_BIT];
  // Command load through internal code 40
  assign w_sec = w_lr & (w_rs == `RS_SEC_CMD);

  assign fin_local = (state_ff == ST_LOCAL) & unit_ack;
  assign fin_ext = (state_ff == ST_EXT_WAIT) & tra_s;
  assign fin_nxd = (state_ff == ST_EXT_WAIT) & ~tra_s & (cnt_ff == NXD_CNT);
  assign fin = fin_local | fin_ext | fin_nxd;
  assign cap_data = fin_local ? unit_rdata : ext_din_s;
  assign cap_par = fin_local ? unit_rpar : ext_par_s;
  // Read parity check, write parity reported by the unit
  assign cap_perr = op_wr_ff ? (fin_local & unit_par_err) :
                    ((fin_local | fin_ext) & (cap_par != odd_par(cap_data)));

  // Set wins over a clear arriving in the same cycle
  assign nxt_rae = (fin & (fin_nxd | cap_perr)) |
                   (register_access_error_ff & ~host_err_clear);
  assign nxt_dis = wr_take ? host_wr_data[`DIS_BIT] : prep_dis_ff;

  drive_unit_regs u_unit (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sel(unit_sel_ff),
    .wr(op_wr_ff),
    .rs(tgt_rs_ff),
    .wdata(tgt_data_ff),
    .wpar(tgt_par_ff),
    .ack_ff(unit_ack),
    .rdata_ff(unit_rdata),
    .rpar_ff(unit_rpar),
    .par_err_ff(unit_par_err),
    .user_data_in(user_data_in),
    .user_data_out_ff(user_data_out_ff),
    .command_ff(command_ff)
  );

  always @(posedge core_clk) begin
    if (!rst_n) begin
      ext_meta_ff <= 18'h00000;
      ext_sync_ff <= 18'h00000;
    end else begin
      ext_meta_ff <= {ext_transfer, ext_par_in, ext_din};
      ext_sync_ff <= ext_meta_ff;
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      prep_rs_ff <= `PREP_RS_RESET;
      prep_lr_ff <= 1'b0;
      prep_dis_ff <= 1'b0;
      prep_b14_ff <= 1'b0;
      prep_ds_ff <= `PREP_DS_RESET;
      prep_fep_ff <= 1'b0;
      state_ff <= ST_IDLE;
      cnt_ff <= `CNT_RESET;
      op_wr_ff <= 1'b0;
      unit_sel_ff <= 1'b0;
      tgt_rs_ff <= `REG_CS1;
      tgt_data_ff <= `DATA_RESET;
      tgt_par_ff <= 1'b0;
      host_rd_data_ff <= `WORD_RESET;
      host_rd_valid_ff <= 1'b0;
      host_busy_ff <= 1'b0;
      register_access_error_ff <= 1'b0;
      err_irq_ff <= 1'b0;
      ext_demand_ff <= 1'b0;
      ext_write_ff <= 1'b0;
      ext_rs_ff <= `REG_CS1;
      ext_ds_ff <= `PREP_DS_RESET;
      ext_dout_ff <= `DATA_RESET;
      ext_dout_oe_ff <= 1'b0;
      ext_par_out_ff <= 1'b0;
    end else begin
      register_access_error_ff <= nxt_rae;
      // Interrupt gated by the disable flag
      err_irq_ff <= nxt_rae & ~nxt_dis;
      host_rd_valid_ff <= 1'b0;
      unit_sel_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (wr_take) begin
            prep_rs_ff <= w_rs;
            prep_lr_ff <= w_lr;
            prep_dis_ff <= host_wr_data[`DIS_BIT];
            prep_b14_ff <= host_wr_data[`B14_BIT];
            prep_ds_ff <= w_ds;
            prep_fep_ff <= w_fep;
            // Load flag and register select decide whether a write cycle runs
            if (w_ext || w_sec) begin
              op_wr_ff <= 1'b1;
              tgt_rs_ff <= w_sec ? `REG_CS1 : w_rs[4:0];
              tgt_data_ff <= w_data;
              tgt_par_ff <= w_fep ? ~odd_par(w_data) : odd_par(w_data);
              host_busy_ff <= 1'b1;
              cnt_ff <= `CNT_RESET;
              if (w_ds == `LOCAL_UNIT) begin
                unit_sel_ff <= 1'b1;
                state_ff <= ST_LOCAL;
              end else begin
                ext_demand_ff <= 1'b1;
                ext_write_ff <= 1'b1;
                ext_rs_ff <= w_sec ? `REG_CS1 : w_rs[4:0];
                ext_ds_ff <= w_ds;
                ext_dout_ff <= w_data;
                ext_dout_oe_ff <= 1'b1;
                ext_par_out_ff <= w_fep ? ~odd_par(w_data) : odd_par(w_data);
                state_ff <= ST_EXT_WAIT;
              end
            end
          end else if (rd_take) begin
            // Reads use the stored preparation fields
            if (prep_rs_ff[`RS_INT_BIT]) begin
              host_rd_data_ff <= pack_result(1'b0, 1'b0, 1'b0, `DATA_RESET);
              host_rd_valid_ff <= 1'b1;
            end else begin
              op_wr_ff <= 1'b0;
              tgt_rs_ff <= prep_rs_ff[4:0];
              host_busy_ff <= 1'b1;
              cnt_ff <= `CNT_RESET;
              if (prep_ds_ff == `LOCAL_UNIT) begin
                unit_sel_ff <= 1'b1;
                state_ff <= ST_LOCAL;
              end else begin
                ext_demand_ff <= 1'b1;
                ext_write_ff <= 1'b0;
                ext_rs_ff <= prep_rs_ff[4:0];
                ext_ds_ff <= prep_ds_ff;
                ext_dout_oe_ff <= 1'b0;
                state_ff <= ST_EXT_WAIT;
              end
            end
          end
        end
        ST_LOCAL: begin
          if (fin_local) begin
            if (!op_wr_ff) begin
              host_rd_data_ff <= pack_result(cap_perr, 1'b1, cap_par, cap_data);
              host_rd_valid_ff <= 1'b1;
            end
            host_busy_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
        ST_EXT_WAIT: begin
          cnt_ff <= cnt_ff + `CNT_ONE;
          if (fin_ext || fin_nxd) begin
            if (!op_wr_ff) begin
              host_rd_data_ff <= pack_result(cap_perr, fin_ext, fin_ext & cap_par,
                                             fin_ext ? cap_data : `DATA_RESET);
              host_rd_valid_ff <= 1'b1;
            end
            ext_demand_ff <= 1'b0;
            ext_dout_oe_ff <= 1'b0;
            ext_write_ff <= 1'b0;
            cnt_ff <= `CNT_RESET;
            // A missing drive never raised transfer, so skip the release wait
            if (fin_nxd) begin
              host_busy_ff <= 1'b0;
              state_ff <= ST_IDLE;
            end else begin
              state_ff <= ST_EXT_REL;
            end
          end
        end
        ST_EXT_REL: begin
          cnt_ff <= cnt_ff + `CNT_ONE;
          // Bounded so a stuck transfer line cannot hang the port
          if (!tra_s || cnt_ff == NXD_CNT) begin
            host_busy_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          host_busy_ff <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> drive_unit_regs.v
`include "drive_access_map.vh"
`timescale 1ns/1ns
`default_nettype none

module drive_unit_regs (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Register access from the controller
  input wire sel,
  input wire wr,
  input wire [4:0] rs,
  input wire [15:0] wdata,
  input wire wpar,
  output reg ack_ff,
  output reg [15:0] rdata_ff,
  output reg rpar_ff,
  output reg par_err_ff,
  // User side
  input wire [15:0] user_data_in,
  output reg [15:0] user_data_out_ff,
  output reg [5:0] command_ff
);

  reg [15:0] din_meta_ff;
  reg [15:0] din_sync_ff;
  wire wpar_ok;
  reg [15:0] rd_mux;

  // Odd parity expected on the control data lines
  assign wpar_ok = (^wdata) ^ wpar;

  always @* begin
    rd_mux = `DATA_RESET;
    case (rs)
      `REG_CS1: begin
        rd_mux[`CS1_CMD_MSB:0] = command_ff;
        rd_mux[`CS1_READY_BIT] = 1'b1;
      end
      `REG_IB: rd_mux = din_sync_ff;
      default: rd_mux = `DATA_RESET;
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      din_meta_ff <= `DATA_RESET;
      din_sync_ff <= `DATA_RESET;
      ack_ff <= 1'b0;
      rdata_ff <= `DATA_RESET;
      rpar_ff <= 1'b1;
      par_err_ff <= 1'b0;
      user_data_out_ff <= `OB_RESET;
      command_ff <= `CS1_RESET;
    end else begin
      din_meta_ff <= user_data_in;
      din_sync_ff <= din_meta_ff;
      ack_ff <= sel;
      if (sel) begin
        par_err_ff <= wr & ~wpar_ok;
        rdata_ff <= rd_mux;
        rpar_ff <= ~(^rd_mux);
        // Corrupted words are dropped, not stored
        if (wr && wpar_ok) begin
          case (rs)
            `REG_CS1: command_ff <= wdata[`CS1_CMD_MSB:0];
            `REG_OB: user_data_out_ff <= wdata;
            default: command_ff <= command_ff;
          endcase
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic host_wr_stb = 1'b0;
  logic [35:0] host_wr_data = 36'h0;
  logic host_rd_stb = 1'b0;
  logic host_err_clear = 1'b0;
  logic [15:0] user_data_in = 16'hBEEF;
  logic [3:0] delay = 4'h1;
  logic bad_par = 1'b0;
  wire [35:0] host_rd_data_ff;
  wire host_rd_valid_ff, host_busy_ff, register_access_error_ff, err_irq_ff;
  wire ext_demand_ff, ext_write_ff, ext_par_out_ff, ext_par_in, ext_transfer;
  wire [4:0] ext_rs_ff;
  wire [2:0] ext_ds_ff;
  wire [15:0] ext_dout_ff, ext_din, user_data_out_ff;
  wire [5:0] command_ff;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [35:0] got;
  always #10 core_clk = ~core_clk;
  drive_register_access_port u_dut (.core_clk, .rst_n, .host_wr_stb, .host_wr_data,
    .host_rd_stb, .host_err_clear, .host_rd_data_ff, .host_rd_valid_ff, .host_busy_ff,
    .register_access_error_ff, .err_irq_ff, .ext_demand_ff, .ext_write_ff, .ext_rs_ff,
    .ext_ds_ff, .ext_dout_ff, .ext_dout_oe_ff(), .ext_par_out_ff, .ext_din, .ext_par_in,
    .ext_transfer, .user_data_in, .user_data_out_ff, .command_ff);
  drive_bus_model u_drv (.core_clk, .rst_n, .demand(ext_demand_ff), .write(ext_write_ff),
    .rs(ext_rs_ff), .ds(ext_ds_ff), .dout(ext_dout_ff), .par_out(ext_par_out_ff),
    .din(ext_din), .par_in(ext_par_in), .transfer(ext_transfer), .delay, .bad_par);
  function automatic logic [35:0] w(input logic [5:0] s, input logic l, input logic x,
      input logic [2:0] d, input logic f, input logic [15:0] v);
    w = {v, 1'b0, f, d, 5'h00, x, 2'h0, l, s};
  endfunction
  function automatic logic [35:0] r(input logic [5:0] s, input logic l, input logic x,
      input logic [2:0] d, input logic t, input logic pe, input logic c, input logic [15:0] v);
    r = {v, c, 1'b0, d, 4'h0, t, x, pe, 1'b0, l, s};
  endfunction
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [35:0] v);
    int n;
    host_wr_stb <= 1'b1;
    host_wr_data <= v;
    @(posedge core_clk);
    host_wr_stb <= 1'b0;
    n = 0;
    repeat (2) @(posedge core_clk);
    while (host_busy_ff === 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 200) chk({35'h0, host_busy_ff}, 36'h0);
    @(posedge core_clk);
  endtask
  task automatic rd(output logic [35:0] v);
    int n;
    logic seen;
    host_rd_stb <= 1'b1;
    @(posedge core_clk);
    host_rd_stb <= 1'b0;
    n = 0;
    seen = 1'b0;
    v = {36{1'bx}};
    // Also wait out the bus release, or the next strobe is dropped while busy
    do begin
      @(posedge core_clk);
      n++;
      if (host_rd_valid_ff === 1'b1) begin
        v = host_rd_data_ff;
        seen = 1'b1;
      end
    end while (!(seen && host_busy_ff === 1'b0) && n < 200);
  endtask
  task automatic clr;
    host_err_clear <= 1'b1;
    @(posedge core_clk);
    host_err_clear <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic t_ext;
    wr(w(6'h05, 1'b1, 1'b0, 3'h2, 1'b0, 16'hA5C3));
    delay <= 4'h6;
    wr(w(6'h05, 1'b0, 1'b0, 3'h2, 1'b0, 16'h1111));
    repeat (2) begin
      rd(got);
      chk(got, r(6'h05, 1'b0, 1'b0, 3'h2, 1'b1, 1'b0, ~^16'hA5C3, 16'hA5C3));
      chk({35'h0, got[19]}, {35'h0, ~^16'hA5C3});
    end
    delay <= 4'h1;
    $display("external access test done");
  endtask
  task automatic t_local;
    wr(w(6'h00, 1'b1, 1'b0, 3'h7, 1'b0, 16'h003F));
    rd(got);
    chk(got, r(6'h00, 1'b1, 1'b0, 3'h7, 1'b1, 1'b0, ~^16'h083F, 16'h083F));
    wr(w(6'h07, 1'b1, 1'b0, 3'h7, 1'b0, 16'h1234));
    chk({20'h0, user_data_out_ff}, 36'h1234);
    wr(w(6'h02, 1'b0, 1'b0, 3'h7, 1'b0, 16'h0000));
    rd(got);
    chk(got, r(6'h02, 1'b0, 1'b0, 3'h7, 1'b1, 1'b0, ~^16'hBEEF, 16'hBEEF));
    $display("local unit test done");
  endtask
  task automatic t_int;
    wr(w(6'h25, 1'b1, 1'b0, 3'h7, 1'b0, 16'h0000));
    rd(got);
    chk(got, r(6'h25, 1'b1, 1'b0, 3'h7, 1'b0, 1'b0, 1'b0, 16'h0000));
    wr(w(6'h20, 1'b1, 1'b0, 3'h7, 1'b0, 16'h0011));
    chk({30'h0, command_ff}, 36'h11);
    wr(w(6'h20, 1'b1, 1'b0, 3'h7, 1'b0, 16'h0024));
    chk({30'h0, command_ff}, 36'h24);
    $display("internal select test done");
  endtask
  task automatic t_nxd;
    wr(w(6'h03, 1'b1, 1'b0, 3'h5, 1'b0, 16'h7777));
    chk({34'h0, register_access_error_ff, err_irq_ff}, 36'h3);
    wr(w(6'h01, 1'b0, 1'b0, 3'h2, 1'b0, 16'h0000));
    rd(got);
    chk(got, r(6'h03, 1'b1, 1'b0, 3'h5, 1'b0, 1'b0, 1'b0, 16'h0000));
    clr();
    $display("missing drive test done");
  endtask
  task automatic t_dis;
    wr(w(6'h03, 1'b1, 1'b1, 3'h5, 1'b0, 16'h0000));
    chk({34'h0, register_access_error_ff, err_irq_ff}, 36'h2);
    wr(w(6'h06, 1'b1, 1'b1, 3'h2, 1'b0, 16'h5A5A));
    rd(got);
    chk(got, r(6'h06, 1'b1, 1'b1, 3'h2, 1'b1, 1'b0, ~^16'h5A5A, 16'h5A5A));
    clr();
    $display("error disable test done");
  endtask
  task automatic t_par;
    wr(w(6'h02, 1'b1, 1'b0, 3'h1, 1'b1, 16'h00F0));
    bad_par <= 1'b1;
    wr(w(6'h05, 1'b0, 1'b0, 3'h2, 1'b0, 16'h0000));
    rd(got);
    chk(got, r(6'h05, 1'b0, 1'b0, 3'h2, 1'b1, 1'b1, ^16'hA5C3, 16'hA5C3));
    @(posedge core_clk);
    chk({35'h0, register_access_error_ff}, 36'h1);
    bad_par <= 1'b0;
    clr();
    $display("parity test done");
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Whole run needs well under 2000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_ext();
    t_local();
    t_int();
    t_nxd();
    t_dis();
    t_par();
    final_report();
  end
endmodule
bind drive_register_access_port access_port_checker u_chk (.core_clk, .rst_n, .host_wr_stb,
  .host_wr_data, .host_rd_data_ff, .host_rd_valid_ff, .host_busy_ff, .register_access_error_ff,
  .err_irq_ff, .ext_demand_ff, .ext_write_ff, .ext_rs_ff, .ext_ds_ff, .ext_dout_ff,
  .ext_par_out_ff, .ext_dout_oe_ff);
`default_nettype wire
